//--- core/converter_pkg.sv
package converter_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_DRIVE_RANGE  = 7'h01;
  localparam logic [6:0] ADDR_TC_ONE       = 7'h02;
  localparam logic [6:0] ADDR_TC_TWO       = 7'h03;
  localparam logic [6:0] ADDR_DIGITAL_CFG  = 7'h04;
  localparam logic [6:0] ADDR_RUN_CONTROL  = 7'h0B;
  localparam logic [6:0] ADDR_MAIN_STATUS  = 7'h20;
  localparam logic [6:0] ADDR_RES_LOW      = 7'h21;
  localparam logic [6:0] ADDR_RES_HIGH     = 7'h22;
  localparam logic [6:0] ADDR_IND_LOW      = 7'h23;
  localparam logic [6:0] ADDR_IND_HIGH     = 7'h24;
  localparam logic [6:0] ADDR_FINE_CNT_LOW = 7'h30;
  localparam logic [6:0] ADDR_FINE_CNT_HI  = 7'h31;
  localparam logic [6:0] ADDR_FINE_BYTE0   = 7'h38;
  localparam logic [6:0] ADDR_FINE_BYTE1   = 7'h39;
  localparam logic [6:0] ADDR_FINE_BYTE2   = 7'h3A;
  localparam logic [6:0] ADDR_FINE_STATUS  = 7'h3B;

  // ----------------------------------------------------------------
  // Slots of the writable registers
  // ----------------------------------------------------------------
  localparam int CFG_BYTES = 7;
  localparam logic [2:0] SLOT_DRIVE    = 3'h0;
  localparam logic [2:0] SLOT_TC_ONE   = 3'h1;
  localparam logic [2:0] SLOT_TC_TWO   = 3'h2;
  localparam logic [2:0] SLOT_DIGITAL_CFG = 3'h3;
  localparam logic [2:0] SLOT_RUN      = 3'h4;
  localparam logic [2:0] SLOT_CNT_LOW  = 3'h5;
  localparam logic [2:0] SLOT_CNT_HIGH = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAX_RES_DISABLE_BIT = 7;
  localparam int MAX_RES_SELECT_LSB  = 4;
  localparam int MIN_RES_SELECT_LSB  = 0;
  localparam int FIRST_CAP_LSB       = 6;
  localparam int FIRST_RES_LSB       = 0;
  localparam int SECOND_CAP_LSB      = 6;
  localparam int SECOND_RES_LSB      = 0;
  localparam int FREQ_FLOOR_LSB      = 4;
  localparam int RESPONSE_LSB        = 0;
  localparam int RUN_STATE_LSB       = 0;
  localparam int MAIN_PENDING_BIT    = 6;
  localparam int FINE_PENDING_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET         = 8'h00;
  localparam logic [7:0] RUN_RESET         = 8'h01;
  localparam logic [1:0] RUN_ACTIVE        = 2'h0;
  localparam logic [1:0] RUN_SLEEP         = 2'h1;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [23:0] POST_PROCESS_CYCLES = 24'h00_0037;
  localparam int          FINE_COUNT_SHIFT    = 4;
  localparam logic [15:0] RESPONSE_BASE       = 16'h0030;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [CFG_BYTES-1:0][7:0] cfg_t;

  typedef struct packed {
    cfg_t                 shadow;
    logic [CFG_BYTES-1:0] written;
    logic                 readRes;
    logic                 readFine;
  } frame_t;

  typedef struct packed {
    cfg_t       cfg;
    logic [7:0] mainStatus;
    logic [7:0] resLow;
    logic [7:0] resHigh;
    logic [7:0] indLow;
    logic [7:0] indHigh;
    logic [7:0] fine0;
    logic [7:0] fine1;
    logic [7:0] fine2;
    logic [7:0] fineStatus;
  } image_t;

endpackage

//--- core/bit_sync.sv
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage <= '0;
      q     <= '0;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

//--- core/spi_link.sv
module spi_link (
  // Link clock, frame and reset
  input  wire logic                   spiClk,
  input  wire logic                   csN,
  input  wire logic                   rstn,
  // Serial data
  input  wire logic                   mosi,
  output logic                        sdo,
  output logic                        sdoOeN,
  // Register image and captured frame
  input  wire converter_pkg::image_t  image,
  output converter_pkg::frame_t       frame
);

  logic [6:0] shiftIn;
  logic [6:0] txShift;
  logic [2:0] bitCnt;
  logic [6:0] addr;
  logic       haveAddr;
  logic       isRead;
  logic       fresh;
  logic [7:0] rxByte;
  logic [3:0] slot;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] slot_of(input logic [6:0] a);
    case (a)
      converter_pkg::ADDR_DRIVE_RANGE:  slot_of = {1'b1, converter_pkg::SLOT_DRIVE};
      converter_pkg::ADDR_TC_ONE:       slot_of = {1'b1, converter_pkg::SLOT_TC_ONE};
      converter_pkg::ADDR_TC_TWO:       slot_of = {1'b1, converter_pkg::SLOT_TC_TWO};
      converter_pkg::ADDR_DIGITAL_CFG:  slot_of = {1'b1, converter_pkg::SLOT_DIGITAL_CFG};
      converter_pkg::ADDR_RUN_CONTROL:  slot_of = {1'b1, converter_pkg::SLOT_RUN};
      converter_pkg::ADDR_FINE_CNT_LOW: slot_of = {1'b1, converter_pkg::SLOT_CNT_LOW};
      converter_pkg::ADDR_FINE_CNT_HI:  slot_of = {1'b1, converter_pkg::SLOT_CNT_HIGH};
      default:                          slot_of = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [6:0] a,
                                           input converter_pkg::image_t img);
    logic [3:0] s;
    s = slot_of(a);
    if (s[3]) begin
      read_byte = img.cfg[s[2:0]];
    end else begin
      case (a)
        converter_pkg::ADDR_MAIN_STATUS: read_byte = img.mainStatus;
        converter_pkg::ADDR_RES_LOW:     read_byte = img.resLow;
        converter_pkg::ADDR_RES_HIGH:    read_byte = img.resHigh;
        converter_pkg::ADDR_IND_LOW:     read_byte = img.indLow;
        converter_pkg::ADDR_IND_HIGH:    read_byte = img.indHigh;
        converter_pkg::ADDR_FINE_BYTE0:  read_byte = img.fine0;
        converter_pkg::ADDR_FINE_BYTE1:  read_byte = img.fine1;
        converter_pkg::ADDR_FINE_BYTE2:  read_byte = img.fine2;
        converter_pkg::ADDR_FINE_STATUS: read_byte = img.fineStatus;
        default:                         read_byte = converter_pkg::UNMAPPED_READ;
      endcase
    end
  endfunction

  assign rxByte = {shiftIn, mosi};
  assign slot   = slot_of(addr);

  // ----------------------------------------------------------------
  // Command byte and address walk
  // ----------------------------------------------------------------
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      shiftIn  <= '0;
      bitCnt   <= '0;
      addr     <= '0;
      haveAddr <= 1'b0;
      isRead   <= 1'b0;
      fresh    <= 1'b1;
    end else begin
      shiftIn <= rxByte[6:0];
      bitCnt  <= bitCnt + 3'd1;
      fresh   <= 1'b0;
      if (bitCnt == 3'd7) begin
        if (!haveAddr) begin
          haveAddr <= 1'b1;
          isRead   <= rxByte[7];
          addr     <= rxByte[6:0];
        end else begin
          addr <= addr + 7'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame capture, held for the register side after the frame ends
  // ----------------------------------------------------------------
  always_ff @(posedge spiClk or negedge rstn) begin
    if (!rstn) begin
      frame <= '0;
    end else begin
      if (fresh) begin
        frame.written  <= '0;
        frame.readRes  <= 1'b0;
        frame.readFine <= 1'b0;
      end
      if (bitCnt == 3'd7 && haveAddr) begin
        if (isRead) begin
          if (addr >= converter_pkg::ADDR_RES_LOW && addr <= converter_pkg::ADDR_IND_HIGH) begin
            frame.readRes <= 1'b1;
          end
          if (addr >= converter_pkg::ADDR_FINE_BYTE0 && addr <= converter_pkg::ADDR_FINE_BYTE2) begin
            frame.readFine <= 1'b1;
          end
        end else if (slot[3]) begin
          frame.shadow[slot[2:0]]  <= rxByte;
          frame.written[slot[2:0]] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data out
  // ----------------------------------------------------------------
  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      sdo     <= 1'b0;
      txShift <= '0;
      sdoOeN  <= 1'b1;
    end else if (haveAddr && isRead) begin
      sdoOeN <= 1'b0;
      if (bitCnt == 3'd0) begin
        {sdo, txShift} <= read_byte(addr, image);
      end else begin
        {sdo, txShift} <= {txShift, 1'b0};
      end
    end
  end

endmodule

//--- core/inductive_sensor_converter_control.sv
// Overview of operation
// - After reset the device sleeps, not converting, and accepts configuration writes.
// - Writing 0x00 to run control at 0x0B starts active conversion.
// - Writing 0x01 to run control at 0x0B halts conversion.
// - Main status bit 6 at 0x20 is low while a new result waits.
// - Resistance code is low byte 0x21 plus 256 times high byte 0x22.
// - Inductance code is low byte 0x23 plus 256 times high byte 0x24.
// - Result registers are read in one burst with automatic address stepping.
// - Fine status bit 0 at 0x3B is low while a new fine result waits.
// - Fine result fills bytes 0x38 to 0x3A, readable in one burst.
// - Each fine conversion adds 55 reference clock cycles after the count interval.
// - The fine path times itself, independent of the resistance path.
// - Frequency floor field sets the watchdog; value 14 selects 4.0 MHz.
// - Response length field sets conversion length; 3072 is encoded b110.
// - First time constant holds capacitor select, 6 pF as b11, and resistor select.
// - Second time constant holds capacitor select up to 24 pF and resistor select.
// - Fine-ready interrupt asserts at first completion, holds until fine data is read.
module inductive_sensor_converter_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial port
  input  wire logic        spiClk,
  input  wire logic        csN,
  input  wire logic        mosi,
  output logic             sdo,
  output logic             sdoOeN,
  // Reference clock, sampled as a level
  input  wire logic        referenceClockIn,
  // Converter front end samples
  input  wire logic [15:0] rpSample,
  input  wire logic [15:0] lSample,
  input  wire logic [23:0] fineSample,
  // Front end configuration
  output logic [7:0]       sensorDriveRange,
  output logic [7:0]       timeConstantOne,
  output logic [7:0]       timeConstantTwo,
  output logic [3:0]       sensorFreqFloor,
  output logic             converting,
  // Fine data ready
  output logic             interruptOutN
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   rstnMeta;
  logic                   rstnSync;
  logic [1:0]             syncIn;
  logic [1:0]             syncOut;
  logic                   csIdle;
  logic                   csIdlePrev;
  logic                   frameEnd;
  logic                   refLevel;
  logic                   refPrev;
  logic                   refEdge;
  converter_pkg::cfg_t    cfg;
  converter_pkg::frame_t  frame;
  converter_pkg::image_t  image;
  logic                   active;
  logic [2:0]             responseCode;
  logic [15:0]            responseCycles;
  logic [15:0]            responseCount;
  logic                   mainDone;
  logic [15:0]            fineReference;
  logic [23:0]            fineCycles;
  logic [23:0]            fineCount;
  logic                   fineDone;
  logic [15:0]            rpResult;
  logic [15:0]            lResult;
  logic [23:0]            fineResult;
  logic                   mainPendingN;
  logic                   finePendingN;
  logic                   next_mainPendingN;
  logic                   next_finePendingN;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstnMeta <= 1'b1;
      rstnSync <= rstnMeta;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The select is synced inverted so that the synchroniser's reset value reads as idle.
  assign syncIn = {~csN, referenceClockIn};

  bit_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk  (clk),
    .rstn (rstnSync),
    .d    (syncIn),
    .q    (syncOut)
  );

  assign csIdle   = ~syncOut[1];
  assign refLevel = syncOut[0];
  assign frameEnd = csIdle & ~csIdlePrev;
  assign refEdge  = refLevel & ~refPrev;

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      csIdlePrev <= 1'b1;
      refPrev    <= 1'b0;
    end else begin
      csIdlePrev <= csIdle;
      refPrev    <= refLevel;
    end
  end

  // ----------------------------------------------------------------
  // Serial link on its own clock
  // ----------------------------------------------------------------
  spi_link u_link (
    .spiClk (spiClk),
    .csN    (csN),
    .rstn   (rstnSync),
    .mosi   (mosi),
    .sdo    (sdo),
    .sdoOeN (sdoOeN),
    .image  (image),
    .frame  (frame)
  );

  // ----------------------------------------------------------------
  // Configuration registers, taken over when a frame ends
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cfg                              <= '0;
      cfg[converter_pkg::SLOT_DRIVE]   <= converter_pkg::CFG_RESET;
      cfg[converter_pkg::SLOT_RUN]     <= converter_pkg::RUN_RESET;
    end else if (frameEnd) begin
      for (int i = 0; i < converter_pkg::CFG_BYTES; i++) begin
        if (frame.written[i]) begin
          cfg[i] <= frame.shadow[i];
        end
      end
    end
  end

  assign active = cfg[converter_pkg::SLOT_RUN][converter_pkg::RUN_STATE_LSB +: 2]
                  == converter_pkg::RUN_ACTIVE;
  assign responseCode  = cfg[converter_pkg::SLOT_DIGITAL_CFG][converter_pkg::RESPONSE_LSB +: 3];
  assign fineReference = {cfg[converter_pkg::SLOT_CNT_HIGH], cfg[converter_pkg::SLOT_CNT_LOW]};

  // ----------------------------------------------------------------
  // Front end configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      sensorDriveRange <= '0;
      timeConstantOne  <= '0;
      timeConstantTwo  <= '0;
      sensorFreqFloor  <= '0;
      converting       <= 1'b0;
    end else begin
      sensorDriveRange <= cfg[converter_pkg::SLOT_DRIVE];
      timeConstantOne  <= cfg[converter_pkg::SLOT_TC_ONE];
      timeConstantTwo  <= cfg[converter_pkg::SLOT_TC_TWO];
      sensorFreqFloor  <=
          cfg[converter_pkg::SLOT_DIGITAL_CFG][converter_pkg::FREQ_FLOOR_LSB +: 4];
      converting       <= active;
    end
  end

  // ----------------------------------------------------------------
  // Resistance and inductance conversion timer
  // ----------------------------------------------------------------
  assign responseCycles = converter_pkg::RESPONSE_BASE << responseCode;
  assign mainDone       = active && (responseCount >= responseCycles - 16'd1);

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      responseCount <= '0;
    end else if (!active || mainDone) begin
      responseCount <= '0;
    end else begin
      responseCount <= responseCount + 16'd1;
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      rpResult <= '0;
      lResult  <= '0;
    end else if (mainDone) begin
      rpResult <= rpSample;
      lResult  <= lSample;
    end
  end

  // ----------------------------------------------------------------
  // Fine inductance conversion timer on reference clock edges
  // ----------------------------------------------------------------
  assign fineCycles = {4'h0, fineReference, 4'h0} + converter_pkg::POST_PROCESS_CYCLES;
  assign fineDone   = active && refEdge && (fineCount >= fineCycles - 24'd1);

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      fineCount <= '0;
    end else if (!active || fineDone) begin
      fineCount <= '0;
    end else if (refEdge) begin
      fineCount <= fineCount + 24'd1;
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      fineResult <= '0;
    end else if (fineDone) begin
      fineResult <= fineSample;
    end
  end

  // ----------------------------------------------------------------
  // Result pending flags; a completion wins over a read clear
  // ----------------------------------------------------------------
  always_comb begin
    next_mainPendingN = mainPendingN;
    next_finePendingN = finePendingN;
    if (frameEnd && frame.readRes) begin
      next_mainPendingN = 1'b1;
    end
    if (frameEnd && frame.readFine) begin
      next_finePendingN = 1'b1;
    end
    if (mainDone) begin
      next_mainPendingN = 1'b0;
    end
    if (fineDone) begin
      next_finePendingN = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      mainPendingN  <= 1'b1;
      finePendingN  <= 1'b1;
      interruptOutN <= 1'b1;
    end else begin
      mainPendingN  <= next_mainPendingN;
      finePendingN  <= next_finePendingN;
      interruptOutN <= next_finePendingN;
    end
  end

  // ----------------------------------------------------------------
  // Read image, frozen while a frame is open
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      image <= '0;
    end else if (csIdle) begin
      image.cfg        <= cfg;
      image.mainStatus <= 8'(mainPendingN) << converter_pkg::MAIN_PENDING_BIT;
      image.resLow     <= rpResult[7:0];
      image.resHigh    <= rpResult[15:8];
      image.indLow     <= lResult[7:0];
      image.indHigh    <= lResult[15:8];
      image.fine0      <= fineResult[7:0];
      image.fine1      <= fineResult[15:8];
      image.fine2      <= fineResult[23:16];
      image.fineStatus <= 8'(finePendingN) << converter_pkg::FINE_PENDING_BIT;
    end
  end

endmodule

//--- sim/host_spi_model.sv
module host_spi_model (
  // Serial port driven by the host
  output logic      spiClk,
  output logic      csN,
  output logic      mosi,
  // Serial port driven by the device
  input  wire logic sdo,
  input  wire logic sdoOeN
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Frames: command byte, then data bytes, MSB first, mode 0
  // ----------------------------------------------------------------
  // Lines settle just after time zero so that the link sees a clean deselect edge.
  initial begin
    #1;
    csN = 1'b1;
    spiClk = 1'b0;
    mosi = 1'b0;
  end

  // The clock stands still between frames.
  // A released data line shows the inverse of its last bit, so a stale value never passes.
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wr,
                       output logic [31:0] rd);
    logic [39:0] tx;
    logic        line;
    tx = {cmd, wr};
    rd = 32'h0000_0000;
    line = 1'b0;
    csN = 1'b0;
    #12;
    for (int i = 0; i < 8 * (n + 1); i++) begin
      mosi = tx[39-i];
      #6;
      spiClk = 1'b1;
      line = sdoOeN ? ~line : sdo;
      if (i >= 8) rd = {rd[30:0], line};
      #6;
      spiClk = 1'b0;
    end
    #12;
    csN = 1'b1;
    #500;
  endtask
endmodule

//--- sim/converter_chk.sv
module converter_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Observed ports
  input wire logic       csN,
  input wire logic       sdoOeN,
  input wire logic [7:0] sensorDriveRange,
  input wire logic [7:0] timeConstantOne,
  input wire logic [7:0] timeConstantTwo,
  input wire logic [3:0] sensorFreqFloor,
  input wire logic       converting,
  input wire logic       interruptOutN
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_idle; $rose(rstn) |-> (!converting && interruptOutN && sdoOeN) [*3]; endproperty
  a_idle: assert property (p_idle) else $error("Outputs not idle after reset");
  property p_run; $changed(converting) |-> csN && $past(csN); endproperty
  a_run: assert property (p_run) else $error("Run state changed inside a frame");
  property p_cfg;
    $changed({sensorDriveRange, timeConstantOne, timeConstantTwo}) |-> csN && $past(csN, 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("Configuration changed inside a frame");
  property p_floor; $changed(sensorFreqFloor) |-> csN && $past(csN, 2); endproperty
  a_floor: assert property (p_floor) else $error("Frequency floor changed in a frame");
  property p_oeIdle; csN && $past(csN) |-> sdoOeN; endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("Data out driven while deselected");
  property p_oeFall; $fell(sdoOeN) |-> !csN; endproperty
  a_oeFall: assert property (p_oeFall) else $error("Data out enabled outside a frame");
  property p_intSet;
    $fell(interruptOutN) |-> $past(converting) || $past(converting, 2) || $past(converting, 3);
  endproperty
  a_intSet: assert property (p_intSet) else $error("Fine ready raised while stopped");
  property p_intClr;
    $rose(interruptOutN) |-> !$past(csN, 2) || !$past(csN, 3) || !$past(csN, 4) || !$past(csN, 5);
  endproperty
  a_intClr: assert property (p_intClr) else $error("Fine ready cleared without a read");
endmodule

bind inductive_sensor_converter_control converter_chk chk (
  .clk(clk), .rstn(rstn), .csN(csN), .sdoOeN(sdoOeN), .sensorDriveRange(sensorDriveRange),
  .timeConstantOne(timeConstantOne), .timeConstantTwo(timeConstantTwo),
  .sensorFreqFloor(sensorFreqFloor), .converting(converting), .interruptOutN(interruptOutN)
);

//--- sim/inductive_sensor_converter_control_bench.sv
module inductive_sensor_converter_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rstn, spiClk, csN, mosi, sdo, sdoOeN, referenceClockIn;
  logic        converting, interruptOutN;
  logic [15:0] rpSample, lSample;
  logic [23:0] fineSample;
  logic [7:0]  sensorDriveRange, timeConstantOne, timeConstantTwo;
  logic [3:0]  sensorFreqFloor;
  int          cycle = 0;
  int          miscompares = 0;
  int          nTests = 0;
  logic [6:0]  cfgAddr [4] = '{7'h01, 7'h02, 7'h03, 7'h04};
  logic [7:0]  cfgVal [4] = '{8'h36, 8'hDE, 8'hFE, 8'hE6};

  inductive_sensor_converter_control dut (
    .clk(clk), .rstn(rstn), .spiClk(spiClk), .csN(csN), .mosi(mosi), .sdo(sdo),
    .sdoOeN(sdoOeN), .referenceClockIn(referenceClockIn), .rpSample(rpSample),
    .lSample(lSample), .fineSample(fineSample), .sensorDriveRange(sensorDriveRange),
    .timeConstantOne(timeConstantOne), .timeConstantTwo(timeConstantTwo),
    .sensorFreqFloor(sensorFreqFloor), .converting(converting),
    .interruptOutN(interruptOutN)
  );
  host_spi_model host (
    .spiClk(spiClk), .csN(csN), .mosi(mosi), .sdo(sdo), .sdoOeN(sdoOeN)
  );

  // ----------------------------------------------------------------
  // Clocks, access tasks and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The reference clock runs at a quarter of the system clock.
  always @(posedge clk) begin
    cycle <= cycle + 1;
    referenceClockIn <= cycle[1];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nTests++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic regWrite(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] unused;
    host.frame({1'b0, a}, 1, {d, 24'h00_0000}, unused);
    @(negedge clk);
  endtask

  task automatic expectReg(input logic [6:0] a, input int n, input logic [31:0] want);
    logic [31:0] r;
    host.frame({1'b1, a}, n, 32'h0000_0000, r);
    @(negedge clk);
    check(r, want);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] r;
    int          c;
    int          t0;
    rstn = 1'b0;
    rpSample = 16'h0000;
    lSample = 16'h0000;
    fineSample = 24'h00_0000;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(negedge clk);
    check(converting, 1'b0);
    expectReg(7'h0B, 1, 32'h0000_0001);
    expectReg(7'h20, 1, 32'h0000_0040);
    expectReg(7'h3B, 1, 32'h0000_0001);
    expectReg(7'h7F, 1, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      regWrite(cfgAddr[i], cfgVal[i]);
      expectReg(cfgAddr[i], 1, {24'h00_0000, cfgVal[i]});
    end
    check({sensorDriveRange, timeConstantOne, timeConstantTwo}, 32'h0036_DEFE);
    check(sensorFreqFloor, 4'hE);
    host.frame(8'h30, 2, 32'h0100_0000, r);
    expectReg(7'h30, 2, 32'h0000_0100);
    @(posedge clk);
    rpSample <= 16'hA55A;
    lSample <= 16'h1234;
    fineSample <= 24'hAB_CDEF;
    regWrite(7'h0B, 8'h00);
    t0 = cycle;
    check(converting, 1'b1);
    for (c = 0; c < 400 && interruptOutN !== 1'b0; c++) @(negedge clk);
    check(c > 265 && c < 295, 1'b1);
    expectReg(7'h3B, 1, 32'h0000_0000);
    check(interruptOutN, 1'b0);
    expectReg(7'h20, 1, 32'h0000_0040);
    expectReg(7'h38, 3, 32'h00EF_CDAB);
    check(interruptOutN, 1'b1);
    r = 32'h0000_0040;
    for (c = 0; c < 500 && r[6] !== 1'b0; c++) host.frame(8'hA0, 1, 32'h0000_0000, r);
    check(cycle - t0 > 3050 && cycle - t0 < 3100, 1'b1);
    expectReg(7'h21, 4, 32'h5AA5_3412);
    expectReg(7'h20, 1, 32'h0000_0040);
    regWrite(7'h0B, 8'h01);
    check(converting, 1'b0);
    expectReg(7'h38, 3, 32'h00EF_CDAB);
    repeat (400) @(negedge clk);
    check(interruptOutN, 1'b1);
    results();
  end
endmodule
